// ===== hdl/render_qual_map.vh
// Register offsets, field positions and reset values of the render command qualifier
`ifndef RENDER_QUAL_MAP_VH
`define RENDER_QUAL_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_RENDER_COMMAND 8'h00
`define ADDR_RASTER_MODE 8'h04
`define ADDR_MASK_PATTERN 8'h08
`define ADDR_DEPTH_WORD 8'h0c
`define ADDR_FB_WRITE_WORD 8'h10
`define ADDR_STENCIL_WORD 8'h14
`define ADDR_COLOUR_WORD 8'h18
`define ADDR_FB_SOURCE_WORD 8'h1c
`define ADDR_UNIT_ENABLES 8'h20
`define ADDR_BLOCK_FILL 8'h24
`define ADDR_FRAG_TOTAL 8'h28
`define ADDR_STATUS 8'h2c
`define ADDR_FRAG_COUNT 8'h30

// ----------------------------------------
// Render command fields
// ----------------------------------------
`define CMD_PRIM_LO 6
`define CMD_PRIM_HI 7
`define CMD_AA_ENABLE 8
`define CMD_MASK_SYNC 11
`define CMD_HOST_SYNC 12
`define CMD_TEXTURE 13
`define CMD_FOG 14
`define CMD_COVERAGE 15
`define CMD_CORRECTION 16
`define CMD_RESERVED 17
`define CMD_SPAN_DATA 18
`define PRIM_TRAPEZOID 2'h1

// ----------------------------------------
// Raster mode, unit enable and status fields
// ----------------------------------------
`define MODE_MSB_FIRST 0
`define MODE_INVERT 1
`define UNIT_TEXTURE 0
`define UNIT_FOG 1
`define UNIT_ALPHA_AA 2
`define STAT_IDLE 0
`define STAT_RUN 1
`define STAT_SUSPENDED 2
`define STAT_ABORTED 3
`define STAT_USED_LO 8

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define RESET_WORD 32'h0000_0000
`define RESET_FRAG_TOTAL 16'h0010
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== hdl/mask_shifter.v
// Rotating cull mask word with end-bit test and consumption count
module mask_shifter #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire rstn,
  input wire load,
  input wire [WIDTH-1:0] load_word,
  input wire consume,
  input wire msb_first,
  input wire invert,
  output wire mask_pass,
  output wire exhausted,
  output wire [6:0] used
);

  localparam [6:0] FULL = WIDTH[6:0];

  reg [WIDTH-1:0] pattern;
  reg [6:0] used_count;
  wire end_bit;

  // ----------------------------------------
  // End bit test
  // ----------------------------------------
  assign end_bit = msb_first ? pattern[WIDTH-1] : pattern[0];
  assign mask_pass = end_bit ^ invert;
  assign exhausted = (used_count == FULL);
  assign used = used_count;

  // Load wins over consume; once all bits are used the word keeps
  // rotating so a stalled mask source simply replays it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pattern <= {WIDTH{1'b0}};
      used_count <= FULL;
    end else if (load) begin
      pattern <= load_word;
      used_count <= 7'h00;
    end else if (consume) begin
      if (msb_first) begin
        pattern <= {pattern[WIDTH-2:0], pattern[WIDTH-1]};
      end else begin
        pattern <= {pattern[0], pattern[WIDTH-1:1]};
      end
      if (!exhausted) begin
        used_count <= used_count + 7'h01;
      end
    end
  end

endmodule // mask_shifter

// ===== hdl/render_qualifier.v
// Render command qualifier: mask and host-data synchronised fragment generation
//
// Function
// - Mask sync: end bit, optionally inverted, culls the fragment when zero.
// - Mask word rotates one position after each fragment under mask sync.
// - Mask exhausted without host sync suspends until a new mask word.
// - Any other register write during suspension aborts, then is processed.
// - With host sync too, exhaustion never suspends; old mask is reused.
// - Host sync: one fragment per write to a fragment data register.
// - Host sync without mask sync: any non-data write aborts.
// - Host sync with mask sync: non-data non-mask write aborts, then processed.
// - Mask word writes never generate a fragment.
// - Texturing needs the command texture gate and the texture unit enable.
// - Fogging needs the command fog gate and the fog unit enable.
// - Coverage weighting needs coverage gate and alpha antialias setting.
// - Scanline start correction only when gated and for aliased trapezoids.
// - Span bit clear writes block fill colour; set uses variable data.
// - Mirror setting consumes mask bits from the MSB, else from the LSB.
// - Invert setting inverts the mask before each bit test.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`include "render_qual_map.vh"

module render_qualifier #(
  parameter ADDR_W = 8,
  parameter MASK_W = 32,
  parameter CNT_W = 16
) (
  input wire clk,
  input wire rstn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg frag_valid,
  output reg frag_keep,
  output reg frag_texture,
  output reg frag_fog,
  output reg frag_coverage,
  output reg frag_line_correct,
  output reg frag_variable_data,
  output reg [31:0] frag_data
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_SUSP = 3'b100;

  // ----------------------------------------
  // Address decode and byte merge helpers
  // ----------------------------------------
  function is_data_reg;
    input [ADDR_W-1:0] a;
    begin
      if (a == `ADDR_DEPTH_WORD) begin
        is_data_reg = 1'b1;
      end else if (a == `ADDR_FB_WRITE_WORD) begin
        is_data_reg = 1'b1;
      end else if (a == `ADDR_STENCIL_WORD) begin
        is_data_reg = 1'b1;
      end else if (a == `ADDR_COLOUR_WORD) begin
        is_data_reg = 1'b1;
      end else if (a == `ADDR_FB_SOURCE_WORD) begin
        is_data_reg = 1'b1;
      end else begin
        is_data_reg = 1'b0;
      end
    end
  endfunction

  function is_mapped;
    input [ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0) begin
        is_mapped = 1'b0;
      end else if (a > `ADDR_FRAG_COUNT) begin
        is_mapped = 1'b0;
      end else begin
        is_mapped = 1'b1;
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] command_word;
  reg [1:0] raster_mode;
  reg [2:0] unit_enables;
  reg [31:0] block_fill_colour;
  reg [CNT_W-1:0] frag_total;
  reg [CNT_W-1:0] remaining;
  reg [31:0] frag_count;
  reg abort_seen;
  reg abort;
  reg frag_fire;
  wire wr_do;
  wire wr_render;
  wire wr_mask;
  wire wr_data_reg;
  wire [31:0] wr_word;
  wire sync_on_mask_bits;
  wire sync_on_host_words;
  wire mask_pass;
  wire mask_exhausted;
  wire [6:0] mask_used;
  wire [1:0] prim_type;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Address and data are caught independently; the write acts once both
  // are held, and no new beat is taken until the response is accepted
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_do = aw_held && w_held && !s_axi_bvalid;
  assign wr_word = merge(32'h0000_0000, w_data, w_strb);
  assign wr_render = wr_do && (aw_addr == `ADDR_RENDER_COMMAND);
  assign wr_mask = wr_do && (aw_addr == `ADDR_MASK_PATTERN);
  assign wr_data_reg = wr_do && is_data_reg(aw_addr);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= `RESET_WORD;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Render command is write-only and the data words are not stored for
  // read back, so those offsets read as zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RESET_WORD;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (s_axi_araddr == `ADDR_RASTER_MODE) begin
        s_axi_rdata <= {30'h0, raster_mode};
      end else if (s_axi_araddr == `ADDR_UNIT_ENABLES) begin
        s_axi_rdata <= {29'h0, unit_enables};
      end else if (s_axi_araddr == `ADDR_BLOCK_FILL) begin
        s_axi_rdata <= block_fill_colour;
      end else if (s_axi_araddr == `ADDR_FRAG_TOTAL) begin
        s_axi_rdata <= {{(32-CNT_W){1'b0}}, frag_total};
      end else if (s_axi_araddr == `ADDR_STATUS) begin
        s_axi_rdata <= {17'h0, mask_used, 4'h0, abort_seen, state[2], state[1], state[0]};
      end else if (s_axi_araddr == `ADDR_FRAG_COUNT) begin
        s_axi_rdata <= frag_count;
      end else begin
        s_axi_rdata <= `RESET_WORD;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      command_word <= `RESET_WORD;
      raster_mode <= 2'h0;
      unit_enables <= 3'h0;
      block_fill_colour <= `RESET_WORD;
      frag_total <= `RESET_FRAG_TOTAL;
    end else if (wr_do) begin
      if (aw_addr == `ADDR_RENDER_COMMAND) begin
        command_word <= wr_word & ~(32'h1 << `CMD_RESERVED);
      end else if (aw_addr == `ADDR_RASTER_MODE) begin
        raster_mode <= wr_word[1:0];
      end else if (aw_addr == `ADDR_UNIT_ENABLES) begin
        unit_enables <= wr_word[2:0];
      end else if (aw_addr == `ADDR_BLOCK_FILL) begin
        block_fill_colour <= merge(block_fill_colour, w_data, w_strb);
      end else if (aw_addr == `ADDR_FRAG_TOTAL) begin
        frag_total <= wr_word[CNT_W-1:0];
      end
    end
  end

  assign sync_on_mask_bits = command_word[`CMD_MASK_SYNC];
  assign sync_on_host_words = command_word[`CMD_HOST_SYNC];
  assign prim_type = command_word[`CMD_PRIM_HI:`CMD_PRIM_LO];

  // ----------------------------------------
  // Cull mask word
  // ----------------------------------------
  mask_shifter #(
    .WIDTH(MASK_W)
  ) u_mask (
    .clk(clk),
    .rstn(rstn),
    .load(wr_mask),
    .load_word(wr_word[MASK_W-1:0]),
    .consume(frag_fire && sync_on_mask_bits),
    .msb_first(raster_mode[`MODE_MSB_FIRST]),
    .invert(raster_mode[`MODE_INVERT]),
    .mask_pass(mask_pass),
    .exhausted(mask_exhausted),
    .used(mask_used)
  );

  // ----------------------------------------
  // Abort and fragment decisions
  // ----------------------------------------
  always @* begin
    abort = 1'b0;
    frag_fire = 1'b0;
    if (state == ST_SUSP) begin
      abort = wr_do && !wr_mask;
    end else if (state == ST_RUN && sync_on_host_words) begin
      if (sync_on_mask_bits) begin
        abort = wr_do && !wr_data_reg && !wr_mask;
      end else begin
        abort = wr_do && !wr_data_reg;
      end
      frag_fire = wr_data_reg;
    end else if (state == ST_RUN) begin
      // Free running: one fragment a cycle unless the mask has run dry or the render command is being written
      frag_fire = !wr_render && !(sync_on_mask_bits && mask_exhausted);
    end
  end

  // ----------------------------------------
  // Rasterizer state machine
  // ----------------------------------------
  // A render write restarts whenever the fragment total is nonzero, so an aborting render command is
  // processed as a fresh primitive rather than dropped
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wr_render && frag_total != {CNT_W{1'b0}}) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wr_render) begin
          next_state = (frag_total != {CNT_W{1'b0}}) ? ST_RUN : ST_IDLE;
        end else if (abort) begin
          next_state = ST_IDLE;
        end else if (frag_fire && remaining == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          next_state = ST_IDLE;
        end else if (!sync_on_host_words && sync_on_mask_bits && mask_exhausted) begin
          next_state = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (wr_render) begin
          next_state = (frag_total != {CNT_W{1'b0}}) ? ST_RUN : ST_IDLE;
        end else if (abort) begin
          next_state = ST_IDLE;
        end else if (wr_mask) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State, fragment budget and sticky abort flag (set wins over clear)
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      remaining <= {CNT_W{1'b0}};
      abort_seen <= 1'b0;
      frag_count <= `RESET_WORD;
    end else begin
      state <= next_state;
      if (wr_render) begin
        remaining <= frag_total;
      end else if (frag_fire) begin
        remaining <= remaining - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (abort) begin
        abort_seen <= 1'b1;
      end else if (wr_do && aw_addr == `ADDR_STATUS && wr_word[`STAT_ABORTED]) begin
        abort_seen <= 1'b0;
      end
      if (frag_fire) begin
        frag_count <= frag_count + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Fragment output and per-primitive gates
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frag_valid <= 1'b0;
      frag_keep <= 1'b0;
      frag_texture <= 1'b0;
      frag_fog <= 1'b0;
      frag_coverage <= 1'b0;
      frag_line_correct <= 1'b0;
      frag_variable_data <= 1'b0;
      frag_data <= `RESET_WORD;
    end else begin
      frag_valid <= frag_fire;
      if (frag_fire) begin
        frag_keep <= sync_on_mask_bits ? mask_pass : 1'b1;
        frag_texture <= command_word[`CMD_TEXTURE] && unit_enables[`UNIT_TEXTURE];
        frag_fog <= command_word[`CMD_FOG] && unit_enables[`UNIT_FOG];
        frag_coverage <= command_word[`CMD_COVERAGE] && unit_enables[`UNIT_ALPHA_AA];
        frag_line_correct <= command_word[`CMD_CORRECTION] && prim_type == `PRIM_TRAPEZOID
          && !command_word[`CMD_AA_ENABLE];
        frag_variable_data <= command_word[`CMD_SPAN_DATA];
        if (!command_word[`CMD_SPAN_DATA]) begin
          frag_data <= block_fill_colour;
        end else if (sync_on_host_words) begin
          frag_data <= wr_word;
        end else begin
          frag_data <= `RESET_WORD; // Framebuffer or pattern data joins downstream
        end
      end
    end
  end

endmodule // render_qualifier

// ===== tb/qual_chk.sv
// Checker tying fragment qualifiers to the command settings last written
`include "render_qual_map.vh"
module qual_chk #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rstn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire frag_valid,
  input wire frag_keep,
  input wire frag_texture,
  input wire frag_fog,
  input wire frag_coverage,
  input wire frag_line_correct,
  input wire frag_variable_data,
  input wire [31:0] frag_data
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [ADDR_W-1:0] wa;
  reg [31:0] wd, cmd, units, fill;
  wire done = s_axi_bvalid && s_axi_bready;
  wire host = cmd[`CMD_HOST_SYNC];
  // ----------------------------------------
  // Shadow of the settings
  // ----------------------------------------
  // Taken when the write completes; strobes ignored, bench writes whole words to these three registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wa <= '0;
      wd <= '0;
      cmd <= '0;
      units <= '0;
      fill <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
      if (done && wa == `ADDR_RENDER_COMMAND) cmd <= wd;
      if (done && wa == `ADDR_UNIT_ENABLES) units <= wd;
      if (done && wa == `ADDR_BLOCK_FILL) fill <= wd;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_tex; frag_valid |-> frag_texture == (cmd[`CMD_TEXTURE] && units[`UNIT_TEXTURE]); endproperty
  a_tex: assert property (p_tex) else $error("texture qualifier wrong");
  property p_fog; frag_valid |-> frag_fog == (cmd[`CMD_FOG] && units[`UNIT_FOG]); endproperty
  a_fog: assert property (p_fog) else $error("fog qualifier wrong");
  property p_cov; frag_valid |-> frag_coverage == (cmd[`CMD_COVERAGE] && units[`UNIT_ALPHA_AA]); endproperty
  a_cov: assert property (p_cov) else $error("coverage qualifier wrong");
  property p_corr; frag_valid |-> frag_line_correct == (cmd[`CMD_CORRECTION] && !cmd[`CMD_AA_ENABLE]
    && cmd[`CMD_PRIM_HI:`CMD_PRIM_LO] == `PRIM_TRAPEZOID); endproperty
  a_corr: assert property (p_corr) else $error("line correction qualifier wrong");
  property p_span; frag_valid |-> frag_variable_data == cmd[`CMD_SPAN_DATA]; endproperty
  a_span: assert property (p_span) else $error("span data kind wrong");
  property p_fill; frag_valid && !cmd[`CMD_SPAN_DATA] |-> frag_data == fill; endproperty
  a_fill: assert property (p_fill) else $error("fill colour not used");
  property p_keep; frag_valid && !cmd[`CMD_MASK_SYNC] |-> frag_keep; endproperty
  a_keep: assert property (p_keep) else $error("fragment culled without mask sync");
  property p_host; frag_valid && host |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_host: assert property (p_host) else $error("host sync fragment without a write");
  property p_mask; done && host && wa == `ADDR_MASK_PATTERN |-> !frag_valid ##1 !frag_valid; endproperty
  a_mask: assert property (p_mask) else $error("mask word write made a fragment");
  // Main scenarios reached
  c_cull: cover property (frag_valid && !frag_keep);
  c_host: cover property (frag_valid && host);
  c_fill: cover property (frag_valid && !frag_variable_data);
endmodule // qual_chk

bind render_qualifier qual_chk #(.ADDR_W(ADDR_W)) chk_u (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .frag_valid,
  .frag_keep, .frag_texture, .frag_fog, .frag_coverage, .frag_line_correct, .frag_variable_data, .frag_data);

// ===== tb/host_axi.sv
// Host processor model issuing AXI4-Lite register writes and reads
module host_axi (
  input wire clk,
  output logic [7:0] awaddr = 8'h00,
  output logic awvalid = 1'b0,
  input wire awready,
  output logic [31:0] wdata = 32'h0000_0000,
  output logic [3:0] wstrb = 4'hf,
  output logic wvalid = 1'b0,
  input wire wready,
  input wire bvalid,
  output logic bready = 1'b0,
  output logic [7:0] araddr = 8'h00,
  output logic arvalid = 1'b0,
  input wire arready,
  input wire rvalid,
  output logic rready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address and data inverted on release so stale values never look valid
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!awready);
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      begin
        do @(posedge clk); while (!wready);
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    join
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask
  // One read at a time, rready held until the data is seen
  task rd(input [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask
endmodule // host_axi

// ===== tb/tb_top.sv
// Self-checking bench for the render command qualifier
`include "render_qual_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata, frag_data;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  wire frag_valid, frag_keep, frag_texture, frag_fog, frag_coverage, frag_line_correct, frag_variable_data;
  integer errors = 0, n_checks = 0, seed = 57, cycles = 0;
  logic [37:0] fq[$];
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [65:0] e;
  logic [31:0] c, u, f, m, d;
  render_qualifier dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frag_valid(frag_valid),
    .frag_keep(frag_keep), .frag_texture(frag_texture), .frag_fog(frag_fog), .frag_coverage(frag_coverage),
    .frag_line_correct(frag_line_correct), .frag_variable_data(frag_variable_data), .frag_data(frag_data));
  host_axi host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
  // ----------------------------------------
  // Clock, timeout and result helpers
  // ----------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  // Ceiling well above the under one thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      tally_and_finish;
    end
  end
  task fail(input string w);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, w);
  endtask
  task cmp(input [65:0] g, input [65:0] x, input string w);
    n_checks++;
    if (g !== x) fail(w);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [1:0] resp(input [7:0] a);
    resp = (a > `ADDR_FRAG_COUNT || a[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
  endfunction
  task wr(input [7:0] a, input [31:0] v, input [3:0] s = 4'hf);
    bq.push_back(resp(a));
    host_u.wr(a, v, s);
  endtask
  // Expected read data is pre-masked so don't-care status bits drop out
  task rd(input [7:0] a, input [31:0] v, input [31:0] k = 32'hffff_ffff);
    rq.push_back({k, resp(a), v & k});
    host_u.rd(a);
  endtask
  function automatic logic kbit(input [31:0] w, input int i, input [1:0] md);
    kbit = w[md[0] ? 31 - i % 32 : i % 32] ^ md[1];
  endfunction
  task drain;
    for (int i = 0; i < 300 && fq.size() > 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    if (fq.size() > 0) fail("fragment missing");
    fq.delete();
  endtask
  // Oldest note taken off its queue as each result shows
  always @(posedge clk) begin
    if (frag_valid && fq.size() == 0) fail("unexpected fragment");
    else if (frag_valid) cmp({frag_keep, frag_texture, frag_fog, frag_coverage, frag_line_correct,
      frag_variable_data, frag_data}, fq.pop_front(), "fragment");
    if (bvalid && bready) cmp(bresp, bq.pop_front(), "write response");
    if (rvalid && rready) begin
      e = rq.pop_front();
      cmp({rresp, rdata & e[65:34]}, e[33:0], "read data");
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`ADDR_STATUS, 32'h2001);
    rd(`ADDR_FRAG_TOTAL, 32'h10);
    rd(`ADDR_RENDER_COMMAND, 0);
    rd(8'h34, 0);
    wr(8'h34, 1);
    wr(`ADDR_FRAG_TOTAL, 32'h00ff_0003, 4'h1);
    rd(`ADDR_FRAG_TOTAL, 3);
    $display("test reset_map done");
    for (int i = 0; i < 8; i++) begin
      c = $random(seed) & 32'h0007_e1c0;
      u = $random(seed) & 7;
      f = $random(seed);
      wr(`ADDR_UNIT_ENABLES, u);
      wr(`ADDR_BLOCK_FILL, f);
      repeat (3) fq.push_back({1'b1, c[13] & u[0], c[14] & u[1], c[15] & u[2],
        c[16] & !c[8] & (c[7:6] == 2'h1), c[18], c[18] ? 32'h0 : f});
      wr(`ADDR_RENDER_COMMAND, c);
      drain;
    end
    $display("test qualifiers done");
    for (int md = 0; md < 4; md++) begin
      m = $random(seed);
      wr(`ADDR_FRAG_TOTAL, 40);
      wr(`ADDR_RASTER_MODE, md);
      wr(`ADDR_MASK_PATTERN, m);
      for (int i = 0; i < 32; i++) fq.push_back({kbit(m, i, md), 5'h0, f});
      wr(`ADDR_RENDER_COMMAND, 32'h800);
      drain;
      rd(`ADDR_STATUS, 32'h2004, 32'h7f07);
      if (md[0]) begin
        m = $random(seed);
        for (int i = 0; i < 8; i++) fq.push_back({kbit(m, i, md), 5'h0, f});
        wr(`ADDR_MASK_PATTERN, m);
        drain;
        rd(`ADDR_STATUS, 1, 7);
      end else begin
        wr(`ADDR_FRAG_TOTAL, 41);
        drain;
        rd(`ADDR_STATUS, 9, 15);
        rd(`ADDR_FRAG_TOTAL, 41);
        wr(`ADDR_STATUS, 8);
      end
    end
    $display("test mask_sync done");
    m = $random(seed);
    wr(`ADDR_RASTER_MODE, 0);
    wr(`ADDR_MASK_PATTERN, m);
    wr(`ADDR_RENDER_COMMAND, 32'h0004_1800);
    for (int i = 0; i < 35; i++) begin
      d = $random(seed);
      if (i == 34) m = $random(seed);
      if (i == 34) wr(`ADDR_MASK_PATTERN, m);
      fq.push_back({kbit(m, i == 34 ? 0 : i, 0), 5'h1, d});
      wr(8'h0c + 8'(i % 5 * 4), d);
    end
    wr(`ADDR_RASTER_MODE, 0);
    rd(`ADDR_STATUS, 9, 15);
    wr(`ADDR_STATUS, 8);
    wr(`ADDR_DEPTH_WORD, d);
    $display("test host_mask_sync done");
    wr(`ADDR_RENDER_COMMAND, 32'h0004_1000);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      fq.push_back({1'b1, 5'h1, d});
      wr(`ADDR_COLOUR_WORD, d);
    end
    wr(`ADDR_BLOCK_FILL, f);
    rd(`ADDR_STATUS, 9, 15);
    wr(`ADDR_FB_SOURCE_WORD, d);
    drain;
    // Fragments made over the whole run: 24 + 144 + 35 + 2
    rd(`ADDR_FRAG_COUNT, 205);
    $display("test host_sync done");
    tally_and_finish;
  end
endmodule // tb_top
